// >>> design/timer2_capture_reload.sv
// Timer with capture, auto-reload and baud generation
`timescale 1ns/1ps
module timer2_capture_reload
    import timer2_pkg::*;
#(
    parameter int PRESCALE_WIDTH = 4
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic [7:0]      rdata_out,
    input  wire logic       trigger_pin_in,
    input  wire logic       external_count_pin_in,
    input  wire logic       tick_rate_select_in,
    input  wire logic       timer1_overflow_in,
    output baud_ticks_type  baud_ticks_out,
    output logic            timer_request_out,
    output logic            clock_out_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    timer_control_type      ctrl_reg, ctrl_next;
    timer_mode_control_type mode_reg, mode_next;
    logic [15:0]            count_reg, count_next;
    logic [15:0]            reload_reg, reload_next;
    logic [PRESCALE_WIDTH-1:0] pre_reg, pre_next;
    logic                   trig_prev_reg, cnt_prev_reg;
    logic [7:0]             rdata_reg, rdata_next;
    baud_ticks_type         baud_reg, baud_next;
    logic                   request_reg, request_next;
    logic                   clk_out_reg, clk_out_next;
    logic                   toggle_reg, toggle_next;

    // ------------------------------------------------------------
    // Decode and events
    // ------------------------------------------------------------
    logic baud_mode, tick, trig_fall, cnt_fall, pre_done;
    logic count_up, up_ovf, down_match, t2_ovf;
    logic edge_hit, capture_hit, reload_edge;
    logic wr_ctrl, wr_mode, wr_low, wr_high, wr_cl, wr_ch;
    logic [PRESCALE_WIDTH-1:0] pre_last;

    assign wr_ctrl = wr_in && (addr_in == TIMER_CONTROL_OFS);
    assign wr_mode = wr_in && (addr_in == TIMER_MODE_CONTROL_OFS);
    assign wr_low  = wr_in && (addr_in == CAPTURE_RELOAD_LOW_OFS);
    assign wr_high = wr_in && (addr_in == CAPTURE_RELOAD_HIGH_OFS);
    assign wr_cl   = wr_in && (addr_in == COUNT_LOW_BYTE_OFS);
    assign wr_ch   = wr_in && (addr_in == COUNT_HIGH_BYTE_OFS);

    assign baud_mode = ctrl_reg.rx_baud_select || ctrl_reg.tx_baud_select;
    assign trig_fall = trig_prev_reg && !trigger_pin_in;
    assign cnt_fall  = cnt_prev_reg && !external_count_pin_in;

    always_comb begin
        if (baud_mode) begin
            pre_last = PRESCALE_WIDTH'(CLKS_PER_TICK_BAUD - 1);
        end else if (tick_rate_select_in) begin
            pre_last = PRESCALE_WIDTH'(CLKS_PER_TICK_FAST - 1);
        end else begin
            pre_last = PRESCALE_WIDTH'(CLKS_PER_TICK_SLOW - 1);
        end
    end
    assign pre_done = (pre_reg >= pre_last);

    // Tick source: baud clock, count pin or prescaler
    always_comb begin
        if (!ctrl_reg.run_control) begin
            tick = 1'b0;
        end else if (baud_mode) begin
            tick = pre_done;
        end else if (ctrl_reg.count_source_select) begin
            tick = cnt_fall;
        end else begin
            tick = pre_done;
        end
    end

    // Direction: down only with down enable and trigger low
    assign count_up = baud_mode || ctrl_reg.capture_reload_select
                      || !mode_reg.down_count_enable || trigger_pin_in;
    assign up_ovf      = tick && count_up && (count_reg == COUNT_MAX);
    assign down_match  = tick && !count_up && (count_reg == reload_reg);
    assign t2_ovf      = up_ovf || down_match;
    assign edge_hit    = trig_fall && ctrl_reg.edge_enable && !baud_mode;
    assign capture_hit = edge_hit && ctrl_reg.capture_reload_select;
    assign reload_edge = edge_hit && !ctrl_reg.capture_reload_select
                         && !mode_reg.down_count_enable;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        ctrl_next    = ctrl_reg;
        mode_next    = mode_reg;
        count_next   = count_reg;
        reload_next  = reload_reg;
        pre_next     = pre_reg;
        rdata_next   = 8'h00;
        baud_next    = '0;
        toggle_next  = toggle_reg;

        if (!ctrl_reg.run_control || pre_done || (!baud_mode && ctrl_reg.count_source_select)) begin
            pre_next = '0;
        end else begin
            pre_next = pre_reg + PRESCALE_WIDTH'(1);
        end

        // Counting
        if (tick) begin
            if (up_ovf && (baud_mode || !ctrl_reg.capture_reload_select)) begin
                count_next = reload_reg;
            end else if (down_match) begin
                count_next = COUNT_MAX;
            end else if (count_up) begin
                count_next = count_reg + 16'h0001;
            end else begin
                count_next = count_reg - 16'h0001;
            end
        end

        // Capture and edge reload
        if (capture_hit) begin
            reload_next = count_reg;
            if (mode_reg.capture_auto_clear) begin
                count_next = COUNT_RESET;
            end
        end else if (reload_edge) begin
            count_next = reload_reg;
        end

        if (t2_ovf && mode_reg.clock_out_enable) begin
            toggle_next = !toggle_reg;
        end

        // Software writes
        if (wr_ctrl) begin
            ctrl_next = timer_control_type'(wdata_in);
        end
        if (wr_mode) begin
            mode_next = timer_mode_control_type'(wdata_in & MODE_MASK);
        end
        if (wr_low) begin
            reload_next[7:0] = wdata_in;
        end
        if (wr_high) begin
            reload_next[15:8] = wdata_in;
        end
        if (wr_cl) begin
            count_next[7:0] = wdata_in;
        end
        if (wr_ch) begin
            count_next[15:8] = wdata_in;
        end

        // Hardware set wins over a same-cycle software clear
        if (t2_ovf && !baud_mode) begin
            ctrl_next.overflow_flag = 1'b1;
        end
        if (edge_hit || (t2_ovf && mode_reg.down_count_enable && !baud_mode)) begin
            ctrl_next.external_edge_flag = 1'b1;
        end
        if (trig_fall && ctrl_reg.edge_enable && baud_mode) begin
            ctrl_next.external_edge_flag = 1'b1;
        end

        // Baud timebases for serial port 0
        baud_next.rx_tick = ctrl_reg.rx_baud_select ? up_ovf : timer1_overflow_in;
        baud_next.tx_tick = ctrl_reg.tx_baud_select ? up_ovf : timer1_overflow_in;

        // Read port
        if (rd_in) begin
            if (addr_in == TIMER_CONTROL_OFS) begin
                rdata_next = ctrl_reg;
            end else if (addr_in == TIMER_MODE_CONTROL_OFS) begin
                rdata_next = mode_reg & MODE_MASK;
            end else if (addr_in == CAPTURE_RELOAD_LOW_OFS) begin
                rdata_next = reload_reg[7:0];
            end else if (addr_in == CAPTURE_RELOAD_HIGH_OFS) begin
                rdata_next = reload_reg[15:8];
            end else if (addr_in == COUNT_LOW_BYTE_OFS) begin
                rdata_next = count_reg[7:0];
            end else if (addr_in == COUNT_HIGH_BYTE_OFS) begin
                rdata_next = count_reg[15:8];
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    assign request_next = ctrl_reg.overflow_flag || ctrl_reg.external_edge_flag;
    assign clk_out_next = mode_reg.clock_out_enable && toggle_next;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl_reg      <= timer_control_type'(CONTROL_RESET);
            mode_reg      <= timer_mode_control_type'(MODE_RESET);
            count_reg     <= COUNT_RESET;
            reload_reg    <= RELOAD_RESET;
            pre_reg       <= '0;
            trig_prev_reg <= 1'b1;
            cnt_prev_reg  <= 1'b1;
            rdata_reg     <= 8'h00;
            baud_reg      <= '0;
            request_reg   <= 1'b0;
            clk_out_reg   <= 1'b0;
            toggle_reg    <= 1'b0;
        end else begin
            ctrl_reg      <= ctrl_next;
            mode_reg      <= mode_next;
            count_reg     <= count_next;
            reload_reg    <= reload_next;
            pre_reg       <= pre_next;
            trig_prev_reg <= trigger_pin_in;
            cnt_prev_reg  <= external_count_pin_in;
            rdata_reg     <= rdata_next;
            baud_reg      <= baud_next;
            request_reg   <= request_next;
            clk_out_reg   <= clk_out_next;
            toggle_reg    <= toggle_next;
        end
    end

    assign rdata_out         = rdata_reg;
    assign baud_ticks_out    = baud_reg;
    assign timer_request_out = request_reg;
    assign clock_out_out     = clk_out_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // ------------------------------------------------------------
    // Checks: flags and request
    // ------------------------------------------------------------
    a_overflow_flag_set: assert property (t2_ovf && !baud_mode |=> ctrl_reg.overflow_flag)
        else $error("overflow flag not set");

    a_no_flag_baud: assert property (baud_mode && !wr_ctrl && !ctrl_reg.overflow_flag
                                     |=> !ctrl_reg.overflow_flag)
        else $error("overflow flag set in baud mode");

    a_flag_sticky: assert property (ctrl_reg.overflow_flag && !wr_ctrl |=> ctrl_reg.overflow_flag)
        else $error("overflow flag lost");

    a_ctrl_write: assert property (wr_ctrl |=> ctrl_reg[5:0] == $past(wdata_in[5:0]))
        else $error("control write lost");

    a_edge_flag_set: assert property (edge_hit |=> ctrl_reg.external_edge_flag)
        else $error("edge flag not set");

    a_edge_sticky: assert property (ctrl_reg.external_edge_flag && !wr_ctrl
                                    |=> ctrl_reg.external_edge_flag)
        else $error("edge flag lost");

    a_request_follows: assert property ((ctrl_reg.overflow_flag || ctrl_reg.external_edge_flag)
                                        |=> timer_request_out)
        else $error("timer request missing");

    a_request_idle: assert property (!(ctrl_reg.overflow_flag || ctrl_reg.external_edge_flag)
                                     |=> !timer_request_out)
        else $error("timer request without flag");

    // ------------------------------------------------------------
    // Checks: baud timebases
    // ------------------------------------------------------------
    a_rx_baud_source: assert property ((ctrl_reg.rx_baud_select ? up_ovf : timer1_overflow_in)
                                       |=> baud_ticks_out.rx_tick)
        else $error("receive baud tick wrong");

    a_rx_tick_idle: assert property (!(ctrl_reg.rx_baud_select ? up_ovf : timer1_overflow_in)
                                     |=> !baud_ticks_out.rx_tick)
        else $error("receive baud tick spurious");

    a_tx_baud_source: assert property ((ctrl_reg.tx_baud_select ? up_ovf : timer1_overflow_in)
                                       |=> baud_ticks_out.tx_tick)
        else $error("transmit baud tick wrong");

    a_tx_tick_idle: assert property (!(ctrl_reg.tx_baud_select ? up_ovf : timer1_overflow_in)
                                     |=> !baud_ticks_out.tx_tick)
        else $error("transmit baud tick spurious");

    a_baud_reload: assert property (up_ovf && baud_mode && !wr_cl && !wr_ch && !wr_low && !wr_high
                                    |=> count_reg == $past(reload_reg))
        else $error("no reload in baud mode");

    a_baud_every_two: assert property (tick && baud_mode && !wr_ctrl ##1 !wr_ctrl
                                       |-> !tick ##1 tick)
        else $error("baud tick spacing wrong");

    // ------------------------------------------------------------
    // Checks: counting
    // ------------------------------------------------------------
    a_ignore_pin: assert property (trig_fall && !ctrl_reg.edge_enable && !tick && !wr_cl && !wr_ch
                                   |=> $stable(count_reg))
        else $error("trigger acted without enable");

    a_run_hold: assert property (!ctrl_reg.run_control && !capture_hit && !reload_edge && !wr_cl && !wr_ch
                                 |=> $stable(count_reg))
        else $error("count moved while stopped");

    a_stop_no_tick: assert property (!ctrl_reg.run_control |-> !tick)
        else $error("tick while stopped");

    a_pin_source: assert property (ctrl_reg.run_control && !baud_mode && ctrl_reg.count_source_select
                                   |-> tick == cnt_fall)
        else $error("count pin tick wrong");

    a_up_count: assert property (tick && count_up && !up_ovf && !capture_hit && !reload_edge
                                 && !wr_cl && !wr_ch
                                 |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("up count wrong");

    a_down_count: assert property (tick && !count_up && !down_match && !reload_edge && !wr_cl && !wr_ch
                                   |=> count_reg == $past(count_reg) - 16'h0001)
        else $error("down count wrong");

    a_down_match: assert property (down_match && !wr_cl && !wr_ch |=> count_reg == COUNT_MAX)
        else $error("down match not wrapped");

    // ------------------------------------------------------------
    // Checks: capture and reload
    // ------------------------------------------------------------
    a_reload_up: assert property (up_ovf && !baud_mode && !ctrl_reg.capture_reload_select
                                  && !wr_cl && !wr_ch
                                  |=> count_reg == $past(reload_reg))
        else $error("no reload on overflow");

    a_edge_reload: assert property (reload_edge && !wr_cl && !wr_ch
                                    |=> count_reg == $past(reload_reg))
        else $error("no reload on trigger edge");

    a_capture_wrap: assert property (up_ovf && !baud_mode && ctrl_reg.capture_reload_select
                                     && !capture_hit && !wr_cl && !wr_ch
                                     |=> count_reg == COUNT_RESET)
        else $error("capture mode wrap wrong");

    a_capture_value: assert property (capture_hit && !wr_low && !wr_high
                                      |=> reload_reg == $past(count_reg))
        else $error("capture value wrong");

    a_capture_clear: assert property (capture_hit && mode_reg.capture_auto_clear && !wr_cl && !wr_ch
                                      |=> count_reg == COUNT_RESET)
        else $error("count not cleared after capture");

    a_low_write: assert property (wr_low |=> reload_reg[7:0] == $past(wdata_in))
        else $error("reload low write lost");

    a_high_write: assert property (wr_high |=> reload_reg[15:8] == $past(wdata_in))
        else $error("reload high write lost");

    // ------------------------------------------------------------
    // Checks: clock out and read port
    // ------------------------------------------------------------
    a_clock_out_off: assert property (!mode_reg.clock_out_enable |=> !clock_out_out)
        else $error("clock out active while disabled");

    a_clock_toggle: assert property (t2_ovf && mode_reg.clock_out_enable
                                     |=> clock_out_out == !$past(toggle_reg))
        else $error("clock out did not toggle");

    a_mode_write: assert property (wr_mode |=> mode_reg == $past(wdata_in & MODE_MASK))
        else $error("mode write lost");

    a_read_idle: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data outside read cycle");

    a_read_count: assert property (rd_in && addr_in == COUNT_LOW_BYTE_OFS
                                   |=> rdata_out == $past(count_reg[7:0]))
        else $error("count read wrong");

endmodule

// >>> design/timer2_pkg.sv
// Constants and types for the capture/reload timer
package timer2_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] TIMER_CONTROL_OFS        = 8'hc8;
    localparam logic [7:0] TIMER_MODE_CONTROL_OFS   = 8'hc9;
    localparam logic [7:0] CAPTURE_RELOAD_LOW_OFS   = 8'hca;
    localparam logic [7:0] CAPTURE_RELOAD_HIGH_OFS  = 8'hcb;
    localparam logic [7:0] COUNT_LOW_BYTE_OFS       = 8'hcc;
    localparam logic [7:0] COUNT_HIGH_BYTE_OFS      = 8'hcd;

    // ------------------------------------------------------------
    // Reset values and field masks
    // ------------------------------------------------------------
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [7:0]  MODE_RESET    = 8'h00;
    localparam logic [7:0]  MODE_MASK     = 8'h0b;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] RELOAD_RESET  = 16'h0000;
    localparam logic [15:0] COUNT_MAX     = 16'hffff;

    // ------------------------------------------------------------
    // Clocks per tick
    // ------------------------------------------------------------
    localparam int CLKS_PER_TICK_SLOW = 12;
    localparam int CLKS_PER_TICK_FAST = 4;
    localparam int CLKS_PER_TICK_BAUD = 2;

    typedef struct packed {
        logic overflow_flag;
        logic external_edge_flag;
        logic rx_baud_select;
        logic tx_baud_select;
        logic edge_enable;
        logic run_control;
        logic count_source_select;
        logic capture_reload_select;
    } timer_control_type;

    typedef struct packed {
        logic [3:0] unused_high;
        logic       capture_auto_clear;
        logic       unused_low;
        logic       clock_out_enable;
        logic       down_count_enable;
    } timer_mode_control_type;

    typedef struct packed {
        logic rx_tick;
        logic tx_tick;
    } baud_ticks_type;

endpackage

// >>> tb/timer2_partner.sv
// Far-side model: trigger pin, count pin, timer 1 overflow
`timescale 1ns/1ps
module timer2_partner #(
    parameter int T1_PERIOD = 8
) (
    input  wire logic clk_in,
    input  wire logic trig_level_in,
    input  wire logic count_pulse_in,
    input  wire logic t1_enable_in,
    output logic      trigger_pin_out,
    output logic      count_pin_out,
    output logic      timer1_overflow_out
);
    int t1_cnt = 0;
    initial begin
        trigger_pin_out = 1'b1;
        count_pin_out = 1'b1;
        timer1_overflow_out = 1'b0;
    end
    always @(posedge clk_in) begin
        trigger_pin_out <= trig_level_in;
        count_pin_out <= !count_pulse_in;
        t1_cnt <= (t1_cnt == T1_PERIOD - 1) ? 0 : t1_cnt + 1;
        timer1_overflow_out <= t1_enable_in && (t1_cnt == 0);
    end
endmodule

// >>> tb/timer2_capture_reload_tb.sv
// Self-checking bench for the capture/reload timer
`timescale 1ns/1ps
module timer2_capture_reload_tb;
    import timer2_pkg::*;
    logic           clk_in      = 1'b0;
    logic           rst_n_in    = 1'b0;
    logic [7:0]     addr        = 8'h00;
    logic [7:0]     wdata       = 8'h00;
    logic           wr          = 1'b0;
    logic           rd          = 1'b0;
    logic           trig_level  = 1'b1;
    logic           count_pulse = 1'b0;
    logic           t1_enable   = 1'b0;
    logic           rate_fast   = 1'b0;
    logic [7:0]     rdata;
    logic           trig_pin;
    logic           count_pin;
    logic           t1_ovf;
    baud_ticks_type ticks;
    logic           request;
    logic           clk_out;
    int             miscompares = 0;
    int             total_checks = 0;
    int             cycles = 0;
    int             n_rx, n_tx, n_clk;

    timer2_capture_reload dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .trigger_pin_in(trig_pin),
        .external_count_pin_in(count_pin), .tick_rate_select_in(rate_fast), .timer1_overflow_in(t1_ovf),
        .baud_ticks_out(ticks), .timer_request_out(request), .clock_out_out(clk_out));
    timer2_partner far (.clk_in(clk_in), .trig_level_in(trig_level), .count_pulse_in(count_pulse),
        .t1_enable_in(t1_enable), .trigger_pin_out(trig_pin), .count_pin_out(count_pin),
        .timer1_overflow_out(t1_ovf));

    initial begin
        forever #5 clk_in = ~clk_in;
    end

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic wr_pair(input logic [7:0] a, input logic [15:0] v);
        wr_reg(a, v[7:0]);
        wr_reg(a + 8'h01, v[15:8]);
    endtask
    task automatic rd_pair(input logic [7:0] a, input logic [15:0] v);
        rd_reg(a, v[7:0]);
        rd_reg(a + 8'h01, v[15:8]);
    endtask
    task automatic pulse_trig;
        trig_level <= 1'b0;
        wait_cyc(4);
        trig_level <= 1'b1;
        wait_cyc(4);
    endtask
    task automatic window(input int n);
        logic last;
        n_rx = 0;
        n_tx = 0;
        n_clk = 0;
        last = clk_out;
        repeat (n) begin
            wait_cyc(1);
            n_rx += int'(ticks.rx_tick === 1'b1);
            n_tx += int'(ticks.tx_tick === 1'b1);
            n_clk += int'(clk_out !== last);
            last = clk_out;
        end
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (logic [7:0] a = TIMER_CONTROL_OFS; a <= COUNT_HIGH_BYTE_OFS; a++) rd_reg(a, 8'h00);
        wr_reg(TIMER_MODE_CONTROL_OFS, 8'hff);
        rd_reg(TIMER_MODE_CONTROL_OFS, MODE_MASK);
        rd_reg(8'hc7, 8'h00);
        wr_reg(TIMER_MODE_CONTROL_OFS, 8'h00);
        for (int f = 0; f < 2; f++) begin
            rate_fast <= f[0];
            wr_pair(COUNT_LOW_BYTE_OFS, 16'h0000);
            wr_reg(TIMER_CONTROL_OFS, 8'h04);
            wait_cyc(f ? 21 : 66);
            wr_reg(TIMER_CONTROL_OFS, 8'h00);
            wait_cyc(30);
            rd_pair(COUNT_LOW_BYTE_OFS, 16'h0005);
        end
        rate_fast <= 1'b0;
        wr_pair(CAPTURE_RELOAD_LOW_OFS, 16'h1234);
        wr_pair(COUNT_LOW_BYTE_OFS, 16'hffff);
        wr_reg(TIMER_CONTROL_OFS, 8'h04);
        wait_cyc(15);
        rd_reg(TIMER_CONTROL_OFS, 8'h84);
        wr_reg(TIMER_CONTROL_OFS, 8'h80);
        rd_pair(COUNT_LOW_BYTE_OFS, 16'h1234);
        chk({7'h00, request}, 8'h01);
        wr_reg(TIMER_CONTROL_OFS, 8'h00);
        wait_cyc(2);
        chk({7'h00, request}, 8'h00);
        wr_reg(TIMER_CONTROL_OFS, 8'h40);
        wait_cyc(2);
        chk({7'h00, request}, 8'h01);
        // Baud generation, both selects, then each alone
        t1_enable <= 1'b1;
        wr_pair(CAPTURE_RELOAD_LOW_OFS, 16'hfffc);
        wr_pair(COUNT_LOW_BYTE_OFS, 16'hfffc);
        wr_reg(TIMER_MODE_CONTROL_OFS, 8'h02);
        for (int b = 0; b < 3; b++) begin
            wr_reg(TIMER_CONTROL_OFS, b == 0 ? 8'h35 : (b == 1 ? 8'h25 : 8'h15));
            wait_cyc(10);
            window(80);
            chk(8'(n_rx), 8'h0a);
            chk(8'(n_tx), 8'h0a);
            chk(8'(n_clk), 8'h0a);
        end
        rd_reg(TIMER_CONTROL_OFS, 8'h15);
        wr_reg(TIMER_MODE_CONTROL_OFS, 8'h00);
        wait_cyc(2);
        window(40);
        chk({clk_out, 7'(n_clk)}, 8'h00);
        t1_enable <= 1'b0;
        // Capture and edge reload; stop the baud count before loading
        wr_reg(TIMER_CONTROL_OFS, 8'h01);
        wr_pair(COUNT_LOW_BYTE_OFS, 16'h5678);
        pulse_trig();
        rd_pair(CAPTURE_RELOAD_LOW_OFS, 16'hfffc);
        rd_reg(TIMER_CONTROL_OFS, 8'h01);
        for (int c = 0; c < 2; c++) begin
            wr_reg(TIMER_MODE_CONTROL_OFS, c ? 8'h08 : 8'h00);
            wr_reg(TIMER_CONTROL_OFS, 8'h09);
            pulse_trig();
            rd_pair(CAPTURE_RELOAD_LOW_OFS, 16'h5678);
            rd_reg(TIMER_CONTROL_OFS, 8'h49);
            rd_pair(COUNT_LOW_BYTE_OFS, c ? 16'h0000 : 16'h5678);
        end
        wr_reg(TIMER_MODE_CONTROL_OFS, 8'h00);
        wr_reg(TIMER_CONTROL_OFS, 8'h08);
        pulse_trig();
        rd_pair(COUNT_LOW_BYTE_OFS, 16'h5678);
        rd_reg(TIMER_CONTROL_OFS, 8'h48);
        // Direction from trigger level
        rate_fast <= 1'b1;
        wr_reg(TIMER_CONTROL_OFS, 8'h00);
        wr_reg(TIMER_MODE_CONTROL_OFS, 8'h01);
        for (int d = 0; d < 2; d++) begin
            trig_level <= d[0];
            wr_pair(COUNT_LOW_BYTE_OFS, 16'h0100);
            wr_reg(TIMER_CONTROL_OFS, 8'h04);
            wait_cyc(21);
            wr_reg(TIMER_CONTROL_OFS, 8'h00);
            rd_pair(COUNT_LOW_BYTE_OFS, d ? 16'h0105 : 16'h00fb);
        end
        trig_level <= 1'b0;
        wr_pair(CAPTURE_RELOAD_LOW_OFS, 16'h00fe);
        wr_pair(COUNT_LOW_BYTE_OFS, 16'h0100);
        wr_reg(TIMER_CONTROL_OFS, 8'h04);
        wait_cyc(22);
        chk({7'h00, request}, 8'h01);
        trig_level <= 1'b1;
        // External count pin
        wr_reg(TIMER_MODE_CONTROL_OFS, 8'h00);
        wr_reg(TIMER_CONTROL_OFS, 8'h00);
        wr_pair(COUNT_LOW_BYTE_OFS, 16'h0000);
        wr_reg(TIMER_CONTROL_OFS, 8'h06);
        repeat (3) begin
            count_pulse <= 1'b1;
            wait_cyc(1);
            count_pulse <= 1'b0;
            wait_cyc(3);
        end
        wait_cyc(30);
        rd_pair(COUNT_LOW_BYTE_OFS, 16'h0003);
        end_of_test();
    end
endmodule
